// >>> core/cfg_link_if.sv
// interface: token link between requester and configuration responder
`default_nettype none
interface cfg_link_if;
	// bit 8 set marks a control token, else a data byte
	logic [8:0] req_data;
	logic req_valid;
	logic req_ready;
	logic [8:0] rsp_data;
	logic rsp_valid;
	logic rsp_ready;
	logic [31:0] dest;
	modport responder (input req_data, input req_valid, output req_ready,
		output rsp_data, output rsp_valid, input rsp_ready, input dest);
	modport requester (output req_data, output req_valid, input req_ready,
		input rsp_data, input rsp_valid, output rsp_ready, output dest);
endinterface : cfg_link_if
`default_nettype wire

// >>> core/cfg_msg_pkg.sv
// package: token codes, field widths and identifiers for config message access
`default_nettype none
package cfg_msg_pkg;
	localparam logic [7:0] TOK_WRITE = 8'hC0;
	localparam logic [7:0] TOK_READ = 8'hC1;
	localparam logic [7:0] TOK_END = 8'h01;
	localparam logic [7:0] TOK_ACK = 8'h03;
	localparam logic [7:0] TOK_NACK = 8'h04;
	localparam logic [7:0] NO_REPLY_LOW = 8'hFF;
	localparam logic [15:0] TILE_BANK_LOW = 16'hC20C;
	localparam logic [15:0] NODE_BANK_LOW = 16'hC30C;
	localparam logic [7:0] PS_RES_TYPE = 8'h0B;
	localparam int PS_SHIFT = 8;
	localparam int REPLY_BYTES = 3;
	localparam int REG_BYTES = 2;
	localparam int DATA_BYTES = 4;
	localparam int LINK_W = 9;
	localparam int FIFO_DEPTH = 4;
	localparam int REG_COUNT = 16;
endpackage : cfg_msg_pkg
`default_nettype wire

// >>> core/cfg_requester.sv
// module: requesting channel-end, serialises read and write messages
`default_nettype none
module cfg_requester
	import cfg_msg_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	cfg_link_if.requester link,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic node_bank_i,
	input wire logic [15:0] target_id_i,
	input wire logic [23:0] reply_id_i,
	input wire logic [15:0] reg_num_i,
	input wire logic [31:0] wdata_i,
	output logic busy_o,
	output logic done_o,
	output logic ok_o,
	output logic [31:0] rdata_o
);
	typedef enum {Q_IDLE, Q_SEND, Q_WAIT} state_e;
	state_e state;
	logic [4:0] idx;
	logic [4:0] last;
	// longest message: command, reply, register, data and end tokens
	localparam int MSG_LEN = REPLY_BYTES + REG_BYTES + DATA_BYTES + 2;
	logic [8:0] tokens [MSG_LEN];
	logic expect_rsp;
	logic pace;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= Q_IDLE;
			idx <= '0;
			last <= '0;
			expect_rsp <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			ok_o <= 1'b0;
			rdata_o <= '0;
			link.dest <= '0;
			for (int k = 0; k < MSG_LEN; k++) tokens[k] <= '0;
		end else begin
			done_o <= 1'b0;
			unique case (state)
				Q_IDLE: if (start_i) begin
					link.dest <= {target_id_i, node_bank_i ? NODE_BANK_LOW : TILE_BANK_LOW};
					tokens[0] <= {1'b1, write_i ? TOK_WRITE : TOK_READ};
					tokens[1] <= {1'b0, reply_id_i[23:16]};
					tokens[2] <= {1'b0, reply_id_i[15:8]};
					tokens[3] <= {1'b0, reply_id_i[7:0]};
					tokens[4] <= {1'b0, reg_num_i[15:8]};
					tokens[5] <= {1'b0, reg_num_i[7:0]};
					tokens[6] <= write_i ? {1'b0, wdata_i[31:24]} : {1'b1, TOK_END};
					tokens[7] <= {1'b0, wdata_i[23:16]};
					tokens[8] <= {1'b0, wdata_i[15:8]};
					tokens[9] <= {1'b0, wdata_i[7:0]};
					tokens[10] <= {1'b1, TOK_END};
					last <= write_i ? 5'(MSG_LEN - 1) : 5'(REPLY_BYTES + REG_BYTES + 1);
					expect_rsp <= !(write_i && reply_id_i[7:0] == NO_REPLY_LOW);
					idx <= '0;
					busy_o <= 1'b1;
					state <= Q_SEND;
				end
				Q_SEND: if (link.req_ready) begin
					idx <= idx + 1'b1;
					if (idx == last) begin
						state <= expect_rsp ? Q_WAIT : Q_IDLE;
						busy_o <= expect_rsp;
						done_o <= !expect_rsp;
						ok_o <= !expect_rsp;
					end
				end
				Q_WAIT: if (link.rsp_valid && link.rsp_ready) begin
					if (link.rsp_data == {1'b1, TOK_ACK}) begin
						ok_o <= 1'b1;
					end else if (link.rsp_data == {1'b1, TOK_NACK}) begin
						ok_o <= 1'b0;
					end else if (link.rsp_data == {1'b1, TOK_END}) begin
						done_o <= 1'b1;
						busy_o <= 1'b0;
						state <= Q_IDLE;
					end else if (!link.rsp_data[8]) begin
						rdata_o <= {rdata_o[23:0], link.rsp_data[7:0]};
					end
				end
			endcase
		end
	end
	// half-rate drain, so the answer buffer sees backpressure
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pace <= 1'b0;
		end else begin
			pace <= !pace;
		end
	end
	assign link.req_valid = (state == Q_SEND);
	assign link.req_data = tokens[idx[3:0]];
	assign link.rsp_ready = (state == Q_WAIT) && pace;
endmodule : cfg_requester
`default_nettype wire

// >>> core/cfg_responder.sv
// module: configuration responder end, decodes request messages and answers them
`default_nettype none
// Operation
// - request carries 24-bit reply channel-end
// - reply low byte all ones: no write answer
// - multi-byte fields sent most significant first
// - status id is number shifted plus 0x0B
// - status access moves one full 32-bit word
// - tile bank destination low half C20C
// - node bank destination low half C30C
// - write: 192, reply, reg, data, 1
// - write answer: 3,1 or 4,1
// - read: 193, reply, reg, 1
// - read answer: 3, data, 1 or 4,1
// - test port clocked, async test reset
module cfg_responder
	import cfg_msg_pkg::*;
#(
	parameter int NREGS = REG_COUNT,
	parameter logic [15:0] BANK_LOW = TILE_BANK_LOW,
	parameter logic [15:0] LOCAL_ID = 16'h0000
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	cfg_link_if.responder link,
	input wire logic [7:0] ps_num_i,
	input wire logic ps_we_i,
	input wire logic [31:0] ps_wdata_i,
	output logic [31:0] ps_rdata_o,
	output logic [15:0] ps_res_id_o,
	output logic [31:0] last_write_o,
	output logic busy_o
);
	typedef enum {S_CMD, S_REPLY, S_REG, S_DATA, S_END, S_ANS, S_VAL, S_CLOSE,
		S_SKIP} state_e;
	state_e state;
	logic is_write;
	logic fail;
	logic [23:0] reply;
	logic [15:0] reg_num;
	logic [31:0] wdata;
	logic [2:0] cnt;
	logic [31:0] regs [NREGS];
	logic [31:0] ps_regs [NREGS];
	logic [31:0] rd_word;
	logic take;
	logic [8:0] in_tok;
	logic in_valid;
	logic in_ready;
	logic [8:0] out_tok;
	logic out_valid;
	logic out_ready;
	logic in_range;
	logic dest_ok;
	logic pace;

	// ----------------------------------------
	// request buffer
	// ----------------------------------------
	token_fifo #(.WIDTH(LINK_W), .DEPTH(FIFO_DEPTH)) req_fifo (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.in_data_i(link.req_data),
		.in_valid_i(link.req_valid),
		.in_ready_o(link.req_ready),
		.out_data_o(in_tok),
		.out_valid_o(in_valid),
		.out_ready_i(in_ready)
	);
	// half-rate intake plus a stall while answering, so the buffer can fill
	assign in_ready = pace && (state != S_ANS) && (state != S_VAL) && (state != S_CLOSE);
	assign take = in_valid && in_ready;
	assign in_range = (reg_num < 16'(NREGS));
	assign dest_ok = (link.dest == {LOCAL_ID, BANK_LOW});
	assign rd_word = regs[reg_num[$clog2(NREGS)-1:0]];
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pace <= 1'b0;
		end else begin
			pace <= !pace;
		end
	end

	// ----------------------------------------
	// message decode
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= S_CMD;
			is_write <= 1'b0;
			fail <= 1'b0;
			reply <= '0;
			reg_num <= '0;
			wdata <= '0;
			cnt <= '0;
		end else begin
			unique case (state)
				S_CMD: if (take) begin
					cnt <= '0;
					fail <= !dest_ok;
					if (in_tok == {1'b1, TOK_WRITE}) begin
						is_write <= 1'b1;
						state <= S_REPLY;
					end else if (in_tok == {1'b1, TOK_READ}) begin
						is_write <= 1'b0;
						state <= S_REPLY;
					end else if (in_tok != {1'b1, TOK_END}) begin
						state <= S_SKIP;
					end
				end
				S_REPLY: if (take) begin
					reply <= {reply[15:0], in_tok[7:0]};
					fail <= fail | in_tok[8];
					cnt <= (cnt == 3'(REPLY_BYTES-1)) ? '0 : cnt + 1'b1;
					if (cnt == 3'(REPLY_BYTES-1)) begin
						state <= S_REG;
					end
				end
				S_REG: if (take) begin
					reg_num <= {reg_num[7:0], in_tok[7:0]};
					fail <= fail | in_tok[8];
					cnt <= (cnt == 3'(REG_BYTES-1)) ? '0 : cnt + 1'b1;
					if (cnt == 3'(REG_BYTES-1)) begin
						state <= is_write ? S_DATA : S_END;
					end
				end
				S_DATA: if (take) begin
					wdata <= {wdata[23:0], in_tok[7:0]};
					fail <= fail | in_tok[8];
					cnt <= (cnt == 3'(DATA_BYTES-1)) ? '0 : cnt + 1'b1;
					if (cnt == 3'(DATA_BYTES-1)) begin
						state <= S_END;
					end
				end
				S_END: if (take) begin
					fail <= fail | !in_range | (in_tok != {1'b1, TOK_END});
					// no answer to a write when the low reply byte is all ones
					state <= (is_write && reply[7:0] == NO_REPLY_LOW) ? S_CMD : S_ANS;
				end
				S_ANS: if (out_ready) begin
					state <= (!is_write && !fail) ? S_VAL : S_CLOSE;
				end
				S_VAL: if (out_ready) begin
					cnt <= (cnt == 3'(DATA_BYTES-1)) ? '0 : cnt + 1'b1;
					if (cnt == 3'(DATA_BYTES-1)) begin
						state <= S_CLOSE;
					end
				end
				S_CLOSE: if (out_ready) begin
					state <= S_CMD;
				end
				S_SKIP: if (take && in_tok == {1'b1, TOK_END}) begin
					state <= S_CMD;
				end
			endcase
		end
	end

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	// write lands on the end token whether or not an answer follows
	always_ff @(posedge clock_i) begin
		if (state == S_END && take && is_write && in_range && !fail
			&& in_tok == {1'b1, TOK_END}) begin
			regs[reg_num[$clog2(NREGS)-1:0]] <= wdata;
		end
		if (ps_we_i) begin
			ps_regs[ps_num_i[$clog2(NREGS)-1:0]] <= ps_wdata_i;
		end
	end

	// ----------------------------------------
	// answer tokens
	// ----------------------------------------
	always_comb begin
		out_valid = 1'b1;
		unique case (state)
			S_ANS: out_tok = {1'b1, fail ? TOK_NACK : TOK_ACK};
			S_VAL: out_tok = {1'b0, rd_word[31 - 8*cnt -: 8]};
			S_CLOSE: out_tok = {1'b1, TOK_END};
			default: begin
				out_tok = '0;
				out_valid = 1'b0;
			end
		endcase
	end

	token_fifo #(.WIDTH(LINK_W), .DEPTH(FIFO_DEPTH)) rsp_fifo (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.in_data_i(out_tok),
		.in_valid_i(out_valid),
		.in_ready_o(out_ready),
		.out_data_o(link.rsp_data),
		.out_valid_o(link.rsp_valid),
		.out_ready_i(link.rsp_ready)
	);

	// ----------------------------------------
	// status port and observation
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ps_rdata_o <= '0;
			ps_res_id_o <= '0;
			last_write_o <= '0;
			busy_o <= 1'b0;
		end else begin
			ps_rdata_o <= ps_regs[ps_num_i[$clog2(NREGS)-1:0]];
			ps_res_id_o <= ({8'h00, ps_num_i} << PS_SHIFT) | {8'h00, PS_RES_TYPE};
			if (state == S_END && take && is_write && in_range && !fail
				&& in_tok == {1'b1, TOK_END}) begin
				last_write_o <= wdata;
			end
			busy_o <= (state != S_CMD);
		end
	end
endmodule : cfg_responder
`default_nettype wire

// >>> core/token_fifo.sv
// module: small valid/ready fifo of parameterised width and depth
`default_nettype none
module token_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : token_fifo
`default_nettype wire

// >>> verification/cfg_link_props.sv
// checker: token link properties between requester and responder
`default_nettype none
module cfg_link_props (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [8:0] req_data,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [8:0] rsp_data,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [31:0] dest
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	logic rq_f, rs_f, rq_end, wr, nr, rfirst;
	logic [3:0] idx;
	logic [2:0] dcnt;
	assign rq_f = req_valid && req_ready;
	assign rs_f = rsp_valid && rsp_ready;
	assign rq_end = rq_f && req_data == 9'h101;
	// ----
	// message tracking
	// ----
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			idx <= 4'h0;
			wr <= 1'b0;
			nr <= 1'b0;
		end else if (rq_f) begin
			idx <= rq_end ? 4'h0 : idx + 4'h1;
			if (idx == 4'h0) wr <= req_data == 9'h1C0;
			if (idx == 4'h3) nr <= req_data[7:0] == 8'hFF;
		end
	end
	// data bytes only counted between first and end answer tokens
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rfirst <= 1'b1;
			dcnt <= 3'h0;
		end else if (rs_f) begin
			rfirst <= rsp_data == 9'h101;
			dcnt <= rsp_data == 9'h101 ? 3'h0 : dcnt + 3'(!rsp_data[8]);
		end
	end
	// ----
	// properties
	// ----
	chk_req_hold:
	assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
		else $error("request token dropped before accept");
	chk_rsp_hold:
	assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
		else $error("answer token dropped before accept");
	chk_dest_bank:
	assert property (req_valid |-> dest[15:0] inside {16'hC20C, 16'hC30C})
		else $error("destination low half not a bank");
	chk_cmd_first:
	assert property (req_valid && idx == 4'h0 |-> req_data inside {9'h1C0, 9'h1C1})
		else $error("message does not open with command");
	chk_msg_len:
	assert property (rq_end |-> idx == (wr ? 4'hA : 4'h6))
		else $error("request length wrong");
	chk_ans_first:
	assert property (rsp_valid && rfirst |-> rsp_data inside {9'h103, 9'h104})
		else $error("answer does not open with status");
	chk_nack_end:
	assert property (rs_f && rsp_data == 9'h104 |=> !rsp_valid || rsp_data == 9'h101)
		else $error("failure token not followed by end");
	chk_ans_len:
	assert property (rs_f && rsp_data == 9'h101 |-> dcnt == 3'h0 || (dcnt == 3'h4 && !wr))
		else $error("answer data length wrong");
	chk_reply_due:
	assert property (rq_end && !(wr && nr) |-> ##[2:40] rsp_valid)
		else $error("answer missing");
	chk_no_reply:
	assert property (rq_end && wr && nr |-> !rsp_valid [*8])
		else $error("answer sent for suppressed write");
endmodule : cfg_link_props
`default_nettype wire

// >>> verification/tb_top.sv
// testbench: requester and responder joined over the token link
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cfg_msg_pkg::*;
	localparam logic [15:0] LID = 16'h0005;
	logic clock_i, rst_b_i, start, write, nbank, busy, done, ok, ps_we, rbusy;
	logic [15:0] tid, regn, ps_id, g;
	logic [23:0] rid, r;
	logic [31:0] wdata, rdata, ps_wdata, ps_rdata, lastw, d;
	logic [7:0] ps_num;
	logic [8:0] rq[$];
	int n_fail = 0;
	int check_count = 0;
	cfg_link_if u_cfg_link_if();
	cfg_requester u_cfg_requester(.clock_i(clock_i), .rst_b_i(rst_b_i), .link(u_cfg_link_if),
		.start_i(start), .write_i(write), .node_bank_i(nbank), .target_id_i(tid),
		.reply_id_i(rid), .reg_num_i(regn), .wdata_i(wdata), .busy_o(busy), .done_o(done),
		.ok_o(ok), .rdata_o(rdata));
	cfg_responder #(.LOCAL_ID(LID)) u_cfg_responder(.clock_i(clock_i), .rst_b_i(rst_b_i),
		.link(u_cfg_link_if), .ps_num_i(ps_num), .ps_we_i(ps_we), .ps_wdata_i(ps_wdata),
		.ps_rdata_o(ps_rdata), .ps_res_id_o(ps_id), .last_write_o(lastw), .busy_o(rbusy));
	cfg_link_props u_cfg_link_props(.clock_i(clock_i), .rst_b_i(rst_b_i),
		.req_data(u_cfg_link_if.req_data), .req_valid(u_cfg_link_if.req_valid),
		.req_ready(u_cfg_link_if.req_ready), .rsp_data(u_cfg_link_if.rsp_data),
		.rsp_valid(u_cfg_link_if.rsp_valid), .rsp_ready(u_cfg_link_if.rsp_ready),
		.dest(u_cfg_link_if.dest));
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (u_cfg_link_if.req_valid && u_cfg_link_if.req_ready) rq.push_back(u_cfg_link_if.req_data);
	end
	// ----
	// helpers
	// ----
	task automatic finish_test();
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : cmp
	function automatic logic [8:0] tok(int i, logic w, int k, logic [71:0] m);
		if (i == 0) return {1'b1, w ? TOK_WRITE : TOK_READ};
		if (i > k) return {1'b1, TOK_END};
		return {1'b0, m[79 - 8 * i -: 8]};
	endfunction : tok
	// waits are bounded; running out ends the run as a failure
	task automatic wait_for(ref logic s, input logic v);
		for (int k = 0; s !== v; k++) begin
			@(posedge clock_i);
			#1;
			if (k > 200) begin
				n_fail++;
				$display("[ERR] %0t wait ran out", $time);
				finish_test();
			end
		end
	endtask : wait_for
	task automatic xfer(input logic w, input logic nb, input logic [15:0] t,
		input logic [23:0] ri, input logic [15:0] gi, input logic [31:0] dv, input logic eok);
		int k;
		k = w ? 9 : 5;
		@(posedge clock_i);
		rq = {};
		write <= w;
		nbank <= nb;
		tid <= t;
		rid <= ri;
		regn <= gi;
		wdata <= dv;
		start <= 1'b1;
		@(posedge clock_i);
		start <= 1'b0;
		#1;
		cmp(32'(busy), 32'h1);
		wait_for(done, 1'b1);
		cmp(32'(busy), 32'h0);
		cmp(32'(ok), 32'(eok));
		if (eok && !w) cmp(rdata, dv);
		wait_for(rbusy, 1'b0);
		cmp(rq.size(), k + 2);
		for (int i = 0; i < rq.size(); i++) cmp(32'(rq[i]), 32'(tok(i, w, k, {ri, gi, dv})));
	endtask : xfer
	// ----
	// sequence
	// ----
	initial begin
		void'($urandom(32'h319f));
		{rst_b_i, start, write, nbank, ps_we, tid, rid, regn, wdata, ps_wdata, ps_num} = '0;
		repeat (6) @(posedge clock_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			@(posedge clock_i);
			ps_num <= 8'(i * 5);
			ps_we <= 1'b1;
			ps_wdata <= d;
			@(posedge clock_i);
			ps_we <= 1'b0;
			@(posedge clock_i);
			#1;
			cmp(ps_rdata, d);
			cmp(32'(ps_id), 32'({8'(i * 5), PS_RES_TYPE}));
		end
		for (int i = 0; i < 6; i++) begin
			g = i == 0 ? 16'h0000 : i == 1 ? 16'h000F : 16'($urandom_range(15));
			d = $urandom;
			r = 24'($urandom) & 24'hFFFF7F;
			xfer(1'b1, 1'b0, LID, r, g, d, 1'b1);
			xfer(1'b0, 1'b0, LID, r, g, d, 1'b1);
		end
		xfer(1'b1, 1'b0, LID, 24'h1234FF, 16'h000F, ~d, 1'b1);
		cmp(lastw, ~d);
		xfer(1'b0, 1'b0, LID, r, 16'h000F, ~d, 1'b1);
		xfer(1'b1, 1'b0, LID, r, 16'h0010, d, 1'b0);
		cmp(lastw, ~d);
		xfer(1'b0, 1'b0, LID, r, 16'h0010, d, 1'b0);
		xfer(1'b0, 1'b1, LID, r, 16'h0003, d, 1'b0);
		xfer(1'b0, 1'b0, LID + 16'h0001, r, 16'h0003, d, 1'b0);
		// mid-run reset: outputs must clear before the next edge
		@(posedge clock_i);
		rst_b_i <= 1'b0;
		#1;
		cmp(32'(ps_id), 32'h0);
		cmp(lastw, 32'h0);
		repeat (3) @(posedge clock_i);
		rst_b_i <= 1'b1;
		d = $urandom;
		xfer(1'b1, 1'b0, LID, r, 16'h0007, d, 1'b1);
		xfer(1'b0, 1'b0, LID, r, 16'h0007, d, 1'b1);
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
